// ### rtl/pll_clock_generator_defines.vh
// Register offsets, field positions and reset values of the clock generator.
// Assumes inclusion by the generator control block only.
`ifndef PLL_CLOCK_GENERATOR_DEFINES_VH
`define PLL_CLOCK_GENERATOR_DEFINES_VH

// ****************************************************************
// Word addresses in the CPU I/O space
// ****************************************************************
`define ADDR_CLOCK_CONFIG_1        16'h1c1e
`define ADDR_CLOCK_CONFIG_2        16'h1c1f
`define ADDR_PLL_MULT_POWER_CTRL   16'h1c20
`define ADDR_REF_DIVIDER_CTRL      16'h1c21
`define ADDR_PLL_INIT_WORD         16'h1c22
`define ADDR_OUTPUT_DIVIDER_CTRL   16'h1c23

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_NORMAL_OPERATION       15
`define BIT_PLL_POWER_OFF          12
`define BIT_REF_DIVIDER_SKIP       15
`define BIT_OUT_DIVIDER_ON         9
`define BIT_SYS_CLOCK_SELECT       0
`define BIT_SDRAM_CLOCK_ON         0
`define BIT_CLOCK_SEL_STAT         2
`define BIT_CLOCK_SRC_LO           4

// ****************************************************************
// Reset values and writable masks
// ****************************************************************
`define RST_PLL_MULT_POWER_CTRL    16'h1000
`define RST_PLL_INIT_WORD          16'h0806
`define MASK_PLL_MULT_POWER_CTRL   16'h9fff
`define MASK_REF_DIVIDER_CTRL      16'h8fff
`define MASK_OUTPUT_DIVIDER_CTRL   16'h02ff
`define MASK_CLOCK_CONFIG_1        16'h0001
`define MASK_CLOCK_CONFIG_2        16'h0009

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_PS              25000
`define PLL_LOCK_TIME_MS           4

`endif

// ### rtl/glitchless_clock_mux.v
// Glitch-free two-input clock multiplexer.
// Assumes both clocks run while a switch is in progress.
`timescale 1ns/1ps

module glitchless_clock_mux (
    input  wire clk_a,
    input  wire clk_b,
    input  wire arst_n,
    input  wire sel_b,
    output wire clk_out,
    output wire b_active
);

    reg [1:0] a_sync_ff;
    reg [1:0] b_sync_ff;
    reg       a_en_ff;
    reg       b_en_ff;

    // ****************************************************************
    // Break-before-make enables, each gated on its own falling edge
    // ****************************************************************
    always @(posedge clk_a or negedge arst_n) begin
        if (!arst_n) begin
            // Starts on clk_a, so sys_clk runs straight out of reset
            a_sync_ff <= 2'h3;
        end else begin
            a_sync_ff <= {a_sync_ff[0], ~sel_b & ~b_en_ff};
        end
    end

    always @(negedge clk_a or negedge arst_n) begin
        if (!arst_n) begin
            a_en_ff <= 1'b1;
        end else begin
            a_en_ff <= a_sync_ff[1];
        end
    end

    always @(posedge clk_b or negedge arst_n) begin
        if (!arst_n) begin
            b_sync_ff <= 2'h0;
        end else begin
            b_sync_ff <= {b_sync_ff[0], sel_b & ~a_en_ff};
        end
    end

    always @(negedge clk_b or negedge arst_n) begin
        if (!arst_n) begin
            b_en_ff <= 1'b0;
        end else begin
            b_en_ff <= b_sync_ff[1];
        end
    end

    assign clk_out  = (clk_a & a_en_ff) | (clk_b & b_en_ff);
    assign b_active = b_en_ff;

endmodule // glitchless_clock_mux

// ### rtl/pll_clock_generator_ctrl.v
// Register file and clock source control of the system clock generator.
// Assumes a single-cycle CPU I/O port on clk and an analog PLL outside.
`timescale 1ns/1ps
`include "pll_clock_generator_defines.vh"

module pll_clock_generator_ctrl #(
    // Both scaled to ns so the product stays inside 32-bit integers
    parameter LOCK_CYCLES = (`PLL_LOCK_TIME_MS * 1000000) /
                            (`CLK_PERIOD_PS / 1000)
) (
    input  wire        clk,
    input  wire        arst_n,
    input  wire        io_sel,
    input  wire        io_we,
    input  wire [15:0] io_addr,
    input  wire [15:0] io_wdata,
    output reg  [15:0] io_rdata,
    output wire        io_hit,
    input  wire        clock_sel_pin,
    input  wire        bypass_clk,
    input  wire        pll_clk,
    output wire        sys_clk,
    output wire        pll_power_off,
    output wire        normal_operation_bit,
    output wire [11:0] pll_multiplier,
    output wire        ref_divider_skip,
    output wire [11:0] ref_divider_value,
    output wire [15:0] pll_init_word,
    output wire        out_divider_on,
    output wire [7:0]  out_divider_value,
    output wire        sdram_clock_on,
    output wire        lock_time_elapsed
);

    reg  [15:0] mult_power_ff;
    reg  [15:0] ref_div_ff;
    reg  [15:0] init_word_ff;
    reg  [15:0] out_div_ff;
    reg  [15:0] cfg1_ff;
    reg  [15:0] cfg2_ff;
    reg  [1:0]  pin_sync_ff;
    reg         sel_active_ff;
    reg  [31:0] lock_cnt_ff;
    reg  [31:0] nxt_lock_cnt;
    reg  [1:0]  src_sync_ff;
    wire        wr;
    wire        src_is_pll;
    wire [15:0] wmask;

    // ****************************************************************
    // Register decode
    // ****************************************************************
    assign wr = io_sel & io_we;
    assign io_hit = io_sel &
        (io_addr >= `ADDR_CLOCK_CONFIG_1) &
        (io_addr <= `ADDR_OUTPUT_DIVIDER_CTRL);
    assign wmask = io_wdata;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mult_power_ff <= `RST_PLL_MULT_POWER_CTRL;
            ref_div_ff    <= 16'h0000;
            init_word_ff  <= `RST_PLL_INIT_WORD;
            out_div_ff    <= 16'h0000;
            cfg1_ff       <= 16'h0000;
            cfg2_ff       <= 16'h0000;
        end else if (wr) begin
            case (io_addr)
                `ADDR_PLL_MULT_POWER_CTRL: begin
                    mult_power_ff <= wmask & `MASK_PLL_MULT_POWER_CTRL;
                end
                `ADDR_REF_DIVIDER_CTRL: begin
                    ref_div_ff <= wmask & `MASK_REF_DIVIDER_CTRL;
                end
                `ADDR_PLL_INIT_WORD: begin
                    init_word_ff <= wmask;
                end
                `ADDR_OUTPUT_DIVIDER_CTRL: begin
                    out_div_ff <= wmask & `MASK_OUTPUT_DIVIDER_CTRL;
                end
                `ADDR_CLOCK_CONFIG_1: begin
                    cfg1_ff <= wmask & `MASK_CLOCK_CONFIG_1;
                end
                `ADDR_CLOCK_CONFIG_2: begin
                    cfg2_ff <= wmask & `MASK_CLOCK_CONFIG_2;
                end
                default: begin
                    // Unlisted addresses hold nothing; writes dropped
                end
            endcase
        end
    end

    // ****************************************************************
    // Strap sampling
    // ****************************************************************
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_sync_ff <= 2'h0;
        end else begin
            pin_sync_ff <= {pin_sync_ff[0], clock_sel_pin};
        end
    end

    // ****************************************************************
    // Source selection
    // ****************************************************************
    // Power-down after PLL mode is not guarded; software owns that hazard
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_active_ff <= 1'b0;
        end else if (!cfg2_ff[`BIT_SYS_CLOCK_SELECT]) begin
            sel_active_ff <= 1'b0;
        end else if (!sel_active_ff &&
                     !mult_power_ff[`BIT_PLL_POWER_OFF]) begin
            sel_active_ff <= 1'b1;
        end
    end

    glitchless_clock_mux u_mux (
        .clk_a    (bypass_clk),
        .clk_b    (pll_clk),
        .arst_n   (arst_n),
        .sel_b    (sel_active_ff),
        .clk_out  (sys_clk),
        .b_active (src_is_pll)
    );

    // ****************************************************************
    // Source status resync
    // ****************************************************************
    // Mux status lives on pll_clk; two flops before the read mux sees it
    // Status only, so a few cycles of lag are harmless
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            src_sync_ff <= 2'h0;
        end else begin
            src_sync_ff <= {src_sync_ff[0], src_is_pll};
        end
    end

    // ****************************************************************
    // Lock time monitor, status only since the PLL has no lock flag
    // ****************************************************************
    always @* begin
        nxt_lock_cnt = lock_cnt_ff;
        if (mult_power_ff[`BIT_PLL_POWER_OFF] ||
            !mult_power_ff[`BIT_NORMAL_OPERATION]) begin
            nxt_lock_cnt = 32'h0;
        end else if (lock_cnt_ff < LOCK_CYCLES) begin
            nxt_lock_cnt = lock_cnt_ff + 32'h1;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lock_cnt_ff <= 32'h0;
        end else begin
            lock_cnt_ff <= nxt_lock_cnt;
        end
    end

    // Saturates at the limit, so the flag stays up until power-down or normal_operation_bit clears
    assign lock_time_elapsed = (lock_cnt_ff >= LOCK_CYCLES);

    // ****************************************************************
    // Read mux
    // ****************************************************************
    always @* begin
        case (io_addr)
            `ADDR_PLL_MULT_POWER_CTRL: io_rdata = mult_power_ff;
            `ADDR_REF_DIVIDER_CTRL:    io_rdata = ref_div_ff;
            `ADDR_PLL_INIT_WORD:       io_rdata = init_word_ff;
            `ADDR_OUTPUT_DIVIDER_CTRL: io_rdata = out_div_ff;
            `ADDR_CLOCK_CONFIG_1:      io_rdata = cfg1_ff;
            `ADDR_CLOCK_CONFIG_2: begin
                io_rdata = cfg2_ff;
                io_rdata[`BIT_CLOCK_SEL_STAT] = pin_sync_ff[1];
                // Bit 3 is plain storage; status bits override stored zeros
                io_rdata[`BIT_CLOCK_SRC_LO] = src_sync_ff[1];
            end
            default:                   io_rdata = 16'h0000;
        endcase
    end

    // ****************************************************************
    // Analog PLL controls
    // ****************************************************************
    assign pll_power_off        = mult_power_ff[`BIT_PLL_POWER_OFF];
    assign normal_operation_bit = mult_power_ff[`BIT_NORMAL_OPERATION];
    assign pll_multiplier       = mult_power_ff[11:0];
    assign ref_divider_skip     = ref_div_ff[`BIT_REF_DIVIDER_SKIP];
    assign ref_divider_value    = ref_div_ff[11:0];
    assign pll_init_word        = init_word_ff;
    assign out_divider_on       = out_div_ff[`BIT_OUT_DIVIDER_ON];
    assign out_divider_value    = out_div_ff[7:0];
    assign sdram_clock_on       = cfg1_ff[`BIT_SDRAM_CLOCK_ON];

endmodule // pll_clock_generator_ctrl

// ### bench/pll_clock_generator_ctrl_monitor.sv
// Checker of the register port of the clock generator control.
// Assumes it is bound onto the control block; one clock domain.
`timescale 1ns/1ps

module pll_clock_generator_ctrl_monitor (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        io_sel,
    input wire logic        io_we,
    input wire logic [15:0] io_addr,
    input wire logic [15:0] io_wdata,
    input wire logic [15:0] io_rdata,
    input wire logic        io_hit,
    input wire logic        pll_power_off,
    input wire logic        normal_operation_bit,
    input wire logic [11:0] pll_multiplier,
    input wire logic [15:0] pll_init_word,
    input wire logic        lock_time_elapsed
);
    // ****
    // Helpers
    // ****
    wire in_map = io_addr >= 16'h1c1e && io_addr <= 16'h1c23;
    wire wr_mp  = io_sel && io_we && io_addr == 16'h1c20;
    wire wr_iw  = io_sel && io_we && io_addr == 16'h1c22;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // ****
    // Properties
    // ****
    property p_hit; io_hit == (io_sel && in_map); endproperty
    a_hit: assert property (p_hit) else $error("bad hit");
    property p_unl; !in_map |-> io_rdata == 16'h0000; endproperty
    a_unl: assert property (p_unl) else $error("unmapped data");
    property p_pwr; wr_mp |=> pll_power_off == $past(io_wdata[12]);
    endproperty
    a_pwr: assert property (p_pwr) else $error("power bit");
    property p_mul; wr_mp |=> pll_multiplier == $past(io_wdata[11:0]);
    endproperty
    a_mul: assert property (p_mul) else $error("multiplier");
    property p_hold; !wr_mp |=> $stable(pll_multiplier)
        && $stable(pll_power_off); endproperty
    a_hold: assert property (p_hold) else $error("held value");
    property p_rd1; io_addr == 16'h1c20 |-> io_rdata ==
        {normal_operation_bit, 2'b00, pll_power_off, pll_multiplier};
    endproperty
    a_rd1: assert property (p_rd1) else $error("reg read");
    property p_init; wr_iw |=> pll_init_word == $past(io_wdata);
    endproperty
    a_init: assert property (p_init) else $error("init write");
    property p_rd3; io_addr == 16'h1c22 |-> io_rdata == pll_init_word;
    endproperty
    a_rd3: assert property (p_rd3) else $error("init read");
    property p_lock; lock_time_elapsed |->
        !$past(pll_power_off) && $past(normal_operation_bit); endproperty
    a_lock: assert property (p_lock) else $error("lock count");
endmodule // pll_clock_generator_ctrl_monitor

// ### bench/pll_clock_generator_ctrl_test.sv
// Self-checking bench of the clock generator control block.
// Assumes the design and its checker are compiled first.
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; \
    $display("ERROR %0t got %h exp %h", $time, (a), (e)); end end

bind pll_clock_generator_ctrl pll_clock_generator_ctrl_monitor mon_inst (
    .clk(clk), .arst_n(arst_n), .io_sel(io_sel), .io_we(io_we),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_hit(io_hit), .pll_power_off(pll_power_off),
    .normal_operation_bit(normal_operation_bit),
    .pll_multiplier(pll_multiplier), .pll_init_word(pll_init_word),
    .lock_time_elapsed(lock_time_elapsed));

module pll_clock_generator_ctrl_test;
    localparam int LOCK = 20;
    logic        clk = 0, arst_n = 0, io_sel = 0, io_we = 0;
    logic        bypass_clk = 0, pll_clk = 0;
    logic [15:0] io_addr = 16'h0000, io_wdata = 16'h0000;
    wire  [15:0] io_rdata, pll_init_word;
    wire  [11:0] pll_multiplier, ref_divider_value;
    wire  [7:0]  out_divider_value;
    wire         io_hit, sys_clk, pll_power_off, normal_operation_bit;
    wire         ref_divider_skip, out_divider_on, sdram_clock_on;
    wire         lock_time_elapsed;
    int          err_total = 0, tests_run = 0, glitch = 0;
    realtime     t_last = 0;

    always #12.5 clk = ~clk;
    always #20 bypass_clk = ~bypass_clk;
    always #4.3 pll_clk = ~pll_clk;

    // Narrowest legal half period is that of pll_clk
    always @(sys_clk) begin
        if (arst_n && $realtime - t_last < 4.0)
            glitch++;
        t_last = $realtime;
    end

    pll_clock_generator_ctrl #(
        .LOCK_CYCLES(LOCK)
    ) pll_clock_generator_ctrl_inst (
        .clk(clk), .arst_n(arst_n), .io_sel(io_sel), .io_we(io_we),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .io_hit(io_hit), .clock_sel_pin(1'b1), .bypass_clk(bypass_clk),
        .pll_clk(pll_clk), .sys_clk(sys_clk), .pll_power_off(pll_power_off),
        .normal_operation_bit(normal_operation_bit),
        .pll_multiplier(pll_multiplier), .ref_divider_skip(ref_divider_skip),
        .ref_divider_value(ref_divider_value), .pll_init_word(pll_init_word),
        .out_divider_on(out_divider_on), .out_divider_value(out_divider_value),
        .sdram_clock_on(sdram_clock_on), .lock_time_elapsed(lock_time_elapsed));

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        io_sel <= 1'b1;
        io_we <= 1'b1;
        io_addr <= a;
        io_wdata <= d;
        @(posedge clk);
        io_sel <= 1'b0;
        io_we <= 1'b0;
    endtask

    task automatic rexp(input logic [15:0] a, input logic [15:0] e);
        @(posedge clk);
        io_sel <= 1'b1;
        io_addr <= a;
        #1;
        `CHK(io_rdata, e)
        @(posedge clk);
        io_sel <= 1'b0;
    endtask

    task automatic t_reset();
        rexp(16'h1c20, 16'h1000);
        rexp(16'h1c21, 16'h0000);
        rexp(16'h1c22, 16'h0806);
        rexp(16'h1c23, 16'h0000);
        rexp(16'h1c1e, 16'h0000);
        rexp(16'h1c1f, 16'h0004);
        #1 `CHK(lock_time_elapsed, 1'b0)
    endtask

    task automatic t_masks();
        logic [15:0] a [5] = '{16'h1c20, 16'h1c21, 16'h1c22, 16'h1c23,
                               16'h1c1e};
        logic [15:0] m [5] = '{16'h9fff, 16'h8fff, 16'hffff, 16'h02ff,
                               16'h0001};
        for (int i = 0; i < 5; i++) begin
            wr(a[i], (i == 0) ? 16'h9fff : 16'hffff);
            rexp(a[i], m[i]);
        end
        `CHK(sdram_clock_on, 1'b1)
        `CHK({pll_power_off, pll_multiplier}, 13'h1fff)
        `CHK({ref_divider_skip, ref_divider_value}, 13'h1fff)
        `CHK({out_divider_on, out_divider_value}, 9'h1ff)
        rexp(16'h1c24, 16'h0000);
        rexp(16'h1c1d, 16'h0000);
        wr(16'h1c1f, 16'h0008);
        rexp(16'h1c1f, 16'h000c);
    endtask

    task automatic t_refuse();
        wr(16'h1c20, 16'h9000);
        wr(16'h1c1f, 16'h0001);
        repeat (20) @(posedge clk);
        rexp(16'h1c1f, 16'h0005);
        wr(16'h1c1f, 16'h0000);
    endtask

    task automatic t_program();
        wr(16'h1c1f, 16'h0000);
        wr(16'h1c20, 16'h1000);
        wr(16'h1c20, 16'h1e4a);
        wr(16'h1c21, 16'h8000);
        wr(16'h1c23, 16'h0202);
        wr(16'h1c22, 16'h0806);
        wr(16'h1c20, 16'h0e4a);
        wr(16'h1c20, 16'h8e4a);
        `CHK({ref_divider_skip, ref_divider_value}, 13'h1000)
        `CHK({out_divider_on, out_divider_value}, 9'h102)
        repeat (LOCK - 4) @(posedge clk);
        #1 `CHK(lock_time_elapsed, 1'b0)
        repeat (8) @(posedge clk);
        #1 `CHK(lock_time_elapsed, 1'b1)
        wr(16'h1c1f, 16'h0001);
        repeat (20) @(posedge clk);
        rexp(16'h1c1f, 16'h0015);
        wr(16'h1c1f, 16'h0000);
        repeat (20) @(posedge clk);
        rexp(16'h1c1f, 16'h0004);
        `CHK(glitch, 0)
    endtask

    task automatic summarize();
        if (err_total == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #100000;
        err_total++;
        summarize();
    end

    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_masks();
        t_refuse();
        t_program();
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        summarize();
    end
endmodule // pll_clock_generator_ctrl_test
